// file: logic/eeprom_pkg.sv
package eeprom_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLOCK_HZ = 40_000_000;          // Core clock rate
    localparam int HZ_PER_MHZ = 1_000_000;         // Unit conversion
    localparam int WRITE_CYCLE_TIME_US = 5000;     // Longest programming time
    // Longest time, so it rounds down to whole cycles
    localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME_US * (CLOCK_HZ / HZ_PER_MHZ);

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int PAGE_COUNT = 64;                // Pages in the array
    localparam int PAGE_BYTES = 16;                // Bytes in one page
    localparam int ADDR_W = 10;                    // Word address width
    localparam int BYTE_W = 8;                     // Bits per byte

    // ------------------------------------------------------------
    // Device address byte layout
    // ------------------------------------------------------------
    localparam int DEV_TYPE_HI = 7;                // Type identifier, top bit
    localparam int DEV_TYPE_LO = 4;                // Type identifier, low bit
    localparam int DEV_SEL_BIT = 3;                // Hardware select bit
    localparam int DEV_ADDR9_BIT = 2;              // Word address bit 9
    localparam int DEV_ADDR8_BIT = 1;              // Word address bit 8
    localparam int DEV_RW_BIT = 0;                 // High reads, low writes
    localparam int ADDR_HI_POS = 8;                // Low bit of the upper pair
    localparam logic [2:0] LAST_BIT = 3'h7;        // Bit count of the eighth bit

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic LINE_IDLE = 1'b1;             // Released bus reads high
    localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

    // ------------------------------------------------------------
    // Link states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,                    // Standby, waits for a start
        ST_DEV       = 4'b0001,                    // Shifting device address
        ST_DEV_ACK   = 4'b0010,                    // Acknowledging device address
        ST_WORD      = 4'b0011,                    // Shifting word address
        ST_WORD_ACK  = 4'b0100,                    // Acknowledging word address
        ST_DATA      = 4'b0101,                    // Shifting the data byte
        ST_DATA_ACK  = 4'b0110,                    // Acknowledging the data byte
        ST_WAIT_STOP = 4'b0111,                    // Data held, stop launches write
        ST_RD_BYTE   = 4'b1000,                    // Sending a read byte
        ST_RD_ACK    = 4'b1001,                    // Master answers read byte
        ST_WRITING   = 4'b1010                     // Programming, bus ignored
    } link_state_e;

endpackage : eeprom_pkg

// file: logic/prog_if.sv
`timescale 1ns/1ps

// Launch and completion of the self-timed programming cycle
interface prog_if;
    logic start;                                   // One-cycle launch pulse
    logic done;                                    // One-cycle completion pulse

    modport ctrl (output start, input done);
    modport timer (input start, output done);
endinterface : prog_if

// file: logic/pin_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for one pin level
module pin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Level in and out
    input wire logic d,
    output logic q
);

    logic meta_r;                                  // First stage, read only by q

    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    // Only the second stage may be looked at by other logic
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_r <= RESET_VAL;
            q <= RESET_VAL;
        end else if (clk_en) begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : pin_sync

// file: logic/write_timer.sv
`timescale 1ns/1ps

// Times the programming cycle from launch to completion
module write_timer #(
    parameter int CYCLES = eeprom_pkg::WRITE_CYCLE_CYCLES
) (
    // Clock and control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Launch and completion
    prog_if.timer pi
);
    import eeprom_pkg::*;

    localparam int CW = $clog2(CYCLES + 1);        // Counter width
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_r;                          // Cycles elapsed
    logic run_r;                                   // Cycle in progress
    logic done_r;                                  // Completion pulse

    assign pi.done = done_r;

    // ------------------------------------------------------------
    // Cycle counter
    // ------------------------------------------------------------
    // A launch while running restarts the count; the controller never does so
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else if (clk_en) begin
            done_r <= run_r && (cnt_r == LAST);
            if (pi.start) begin
                run_r <= 1'b1;
                cnt_r <= '0;
            end else if (run_r && (cnt_r == LAST)) begin
                run_r <= 1'b0;
            end else if (run_r) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

endmodule : write_timer

// file: logic/eeprom_bus_slave.sv
// How it works
// [RULE_01] Start is SDA falling while SCL high
// [RULE_02] All bus activity ignored until a start
// [RULE_03] Stop is SDA rising while SCL high
// [RULE_04] Repeated start accepted in place of stop
// [RULE_05] Receiver holds SDA low through ninth clock
// [RULE_06] Receiver releases SDA after ninth clock
// [RULE_07] Master no-acknowledge makes device release SDA
// [RULE_08] Standby after reset, stop, write, mismatch, no-acknowledge
// [RULE_09] Dummy clocks end with SDA released high
// [RULE_10] Sixty-four pages of sixteen, ten-bit address
// [RULE_11] Type identifier in bits seven to four
// [RULE_12] Bit three matches hardware select input
// [RULE_13] Address byte bits two, one give bits 9:8
// [RULE_14] Bit zero high reads, low writes
// [RULE_15] Acknowledge matching address, refuse mismatching one
// [RULE_16] Word address byte follows device address
// [RULE_17] Write is address, word, then data
// [RULE_18] Byte write acknowledges three bytes, then stop
// [RULE_19] Stop after acked data launches timed programming
// [RULE_20] Bus ignored while programming runs
// [RULE_21] Capture on SCL rise, change after fall
// [RULE_22] Most significant first, nine clocks per byte
// [RULE_23] Pins synchronised, edges found from samples
`timescale 1ns/1ps

module eeprom_bus_slave #(
    // Arbitrary neutral type identifier; set to the product's own value
    parameter logic [3:0] DEVICE_TYPE_ID = 4'h5,
    // Shorten in simulation; default is the longest programming time
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLE_CYCLES
) (
    // Clock and control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Strap
    input wire logic hw_select_bit,
    // Memory side
    input wire logic [eeprom_pkg::BYTE_W-1:0] rd_data,
    output logic [eeprom_pkg::ADDR_W-1:0] word_addr,
    output logic prog_start,
    output logic [eeprom_pkg::ADDR_W-1:0] prog_addr,
    output logic [eeprom_pkg::BYTE_W-1:0] prog_data,
    // Status
    output logic busy,
    output logic standby
);
    import eeprom_pkg::*;

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    logic scl_s;                                   // Synchronised clock line
    logic sda_s;                                   // Synchronised data line
    logic sel_s;                                   // Synchronised select strap
    logic scl_d_r;                                 // Previous clock sample
    logic sda_d_r;                                 // Previous data sample

    pin_sync #(.RESET_VAL(LINE_IDLE)) u_scl_sync (.clock(clock), .rst_n(rst_n),
        .clk_en(clk_en), .d(scl_in), .q(scl_s)); // [RULE_23]

    pin_sync #(.RESET_VAL(LINE_IDLE)) u_sda_sync (.clock(clock), .rst_n(rst_n),
        .clk_en(clk_en), .d(sda_in), .q(sda_s)); // [RULE_23]

    // Unconnected strap is pulled low outside, so low is the safe reset value
    pin_sync #(.RESET_VAL(1'b0)) u_sel_sync (.clock(clock), .rst_n(rst_n),
        .clk_en(clk_en), .d(hw_select_bit), .q(sel_s)); // [RULE_12]

    // Programming timer; the sequencer stays deaf until it reports done
    prog_if pi ();
    write_timer #(.CYCLES(WRITE_CYCLES)) u_timer (.clock(clock), .rst_n(rst_n),
        .clk_en(clk_en), .pi(pi));

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    // Start and stop need SCL high in both samples, so a data change that
    // merely races a clock edge is taken as data, not as a condition
    wire scl_rise = scl_s & ~scl_d_r; // [RULE_21]
    wire scl_fall = ~scl_s & scl_d_r; // [RULE_21]
    wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s; // [RULE_01]
    wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s; // [RULE_03]

    // ------------------------------------------------------------
    // State and next values
    // ------------------------------------------------------------
    link_state_e state_r, state_nxt;               // Link sequencer
    logic [2:0] bit_cnt_r, bit_cnt_nxt;            // Rising edges in this byte
    logic full_r, full_nxt;                        // Eighth bit taken
    logic [BYTE_W-1:0] shift_r, shift_nxt;         // Receive shifter
    logic [BYTE_W-1:0] tx_r, tx_nxt;               // Transmit shifter
    logic rw_r, rw_nxt;                            // Operation of this command
    logic master_ack_r, master_ack_nxt;            // Master answer to read byte
    logic sda_oe_r, sda_oe_nxt;                    // Pulling SDA low
    logic sda_out_r;                               // Open-drain level, always low
    logic [ADDR_W-1:0] word_addr_r, word_addr_nxt; // Address counter
    logic prog_start_r, prog_start_nxt;            // Launch pulse
    logic [ADDR_W-1:0] prog_addr_r, prog_addr_nxt; // Address to program
    logic [BYTE_W-1:0] prog_data_r, prog_data_nxt; // Byte to program
    logic busy_r, busy_nxt;                        // Programming in progress
    logic standby_r, standby_nxt;                  // Low-power standby

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire [BYTE_W-1:0] rx_byte = {shift_r[BYTE_W-2:0], sda_s}; // [RULE_22]
    wire type_ok = shift_r[DEV_TYPE_HI:DEV_TYPE_LO] == DEVICE_TYPE_ID; // [RULE_11]
    wire sel_ok = shift_r[DEV_SEL_BIT] == sel_s; // [RULE_12]
    wire dev_match = type_ok & sel_ok; // [RULE_15]
    wire dev_read = shift_r[DEV_RW_BIT]; // [RULE_14]
    wire [1:0] addr_hi = {shift_r[DEV_ADDR9_BIT], shift_r[DEV_ADDR8_BIT]}; // [RULE_13]
    wire rx_state = (state_r == ST_DEV) | (state_r == ST_WORD) | (state_r == ST_DATA);
    wire byte_end = scl_fall & full_r;             // Fall that ends the eighth bit
    wire [ADDR_W-1:0] addr_inc = word_addr_r + 1'b1; // [RULE_10]

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Start and stop take priority over bit traffic in every state but the
    // programming one, which is deaf to the bus until the timer finishes
    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        full_nxt = full_r;
        shift_nxt = shift_r;
        tx_nxt = tx_r;
        rw_nxt = rw_r;
        master_ack_nxt = master_ack_r;
        sda_oe_nxt = sda_oe_r;
        word_addr_nxt = word_addr_r;
        prog_start_nxt = 1'b0;
        prog_addr_nxt = prog_addr_r;
        prog_data_nxt = prog_data_r;
        busy_nxt = busy_r;
        standby_nxt = standby_r;
        if (state_r == ST_WRITING) begin
            // Inputs are disabled until the cycle completes
            sda_oe_nxt = 1'b0; // [RULE_20]
            if (pi.done) begin
                state_nxt = ST_IDLE; // [RULE_08]
                busy_nxt = 1'b0;
                standby_nxt = 1'b1;
            end
        end else if (start_det) begin
            // Also covers a repeated start in mid-command
            state_nxt = ST_DEV; // [RULE_04]
            bit_cnt_nxt = 3'h0;
            full_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
            standby_nxt = 1'b0; // [RULE_01]
        end else if (stop_det) begin
            sda_oe_nxt = 1'b0;
            if (state_r == ST_WAIT_STOP) begin
                // Acked data byte held: launch programming
                state_nxt = ST_WRITING; // [RULE_19]
                prog_start_nxt = 1'b1;
                prog_addr_nxt = word_addr_r;
                word_addr_nxt = addr_inc;
                busy_nxt = 1'b1;
            end else begin
                state_nxt = ST_IDLE; // [RULE_03]
                standby_nxt = 1'b1; // [RULE_08]
            end
        end else if (rx_state) begin
            // Receive a byte, most significant bit first
            if (scl_rise) begin
                shift_nxt = rx_byte; // [RULE_21]
                bit_cnt_nxt = bit_cnt_r + 1'b1;
                full_nxt = (bit_cnt_r == LAST_BIT); // [RULE_22]
            end else if (byte_end) begin
                full_nxt = 1'b0;
                bit_cnt_nxt = 3'h0;
                // Pull low for the ninth clock after the eighth falling edge
                sda_oe_nxt = 1'b1; // [RULE_05]
                unique case (state_r)
                    ST_DEV: begin
                        if (dev_match) begin
                            state_nxt = ST_DEV_ACK; // [RULE_15]
                            rw_nxt = dev_read;
                            // Upper pair only loads on a write; a read
                            // reuses the counter as it stands
                            if (!dev_read) begin
                                word_addr_nxt[ADDR_W-1:ADDR_HI_POS] = addr_hi; // [RULE_13]
                            end
                        end else begin
                            // No acknowledge, back to standby
                            sda_oe_nxt = 1'b0; // [RULE_15]
                            state_nxt = ST_IDLE; // [RULE_08]
                            standby_nxt = 1'b1;
                        end
                    end
                    ST_WORD: begin
                        word_addr_nxt[ADDR_HI_POS-1:0] = shift_r; // [RULE_16]
                        state_nxt = ST_WORD_ACK;
                    end
                    default: begin
                        prog_data_nxt = shift_r; // [RULE_18]
                        state_nxt = ST_DATA_ACK;
                    end
                endcase
            end
        end else begin
            unique case (state_r)
                ST_IDLE, ST_WAIT_STOP: begin
                    // Standby, or data held and only a stop or a start matters; extra
                    // bytes get no acknowledge since page mode is absent
                    sda_oe_nxt = 1'b0; // [RULE_02]
                end
                ST_DEV_ACK: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            // First read bit goes out right after the fall
                            state_nxt = ST_RD_BYTE; // [RULE_14]
                            tx_nxt = rd_data;
                            sda_oe_nxt = ~rd_data[BYTE_W-1]; // [RULE_21]
                        end else begin
                            state_nxt = ST_WORD; // [RULE_17]
                            sda_oe_nxt = 1'b0; // [RULE_06]
                        end
                    end
                end
                ST_WORD_ACK: begin
                    if (scl_fall) begin
                        state_nxt = ST_DATA; // [RULE_17]
                        sda_oe_nxt = 1'b0; // [RULE_06]
                    end
                end
                ST_DATA_ACK: begin
                    if (scl_fall) begin
                        state_nxt = ST_WAIT_STOP; // [RULE_18]
                        sda_oe_nxt = 1'b0; // [RULE_06]
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_rise) begin
                        bit_cnt_nxt = bit_cnt_r + 1'b1;
                        full_nxt = (bit_cnt_r == LAST_BIT); // [RULE_22]
                    end else if (byte_end) begin
                        // Release for the master's answer
                        full_nxt = 1'b0;
                        bit_cnt_nxt = 3'h0;
                        sda_oe_nxt = 1'b0; // [RULE_05]
                        word_addr_nxt = addr_inc; // [RULE_10]
                        state_nxt = ST_RD_ACK;
                    end else if (scl_fall) begin
                        tx_nxt = {tx_r[BYTE_W-2:0], 1'b0};
                        sda_oe_nxt = ~tx_r[BYTE_W-2]; // [RULE_21]
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        master_ack_nxt = ~sda_s; // [RULE_21]
                    end else if (scl_fall) begin
                        if (master_ack_r) begin
                            state_nxt = ST_RD_BYTE;
                            tx_nxt = rd_data;
                            sda_oe_nxt = ~rd_data[BYTE_W-1];
                        end else begin
                            // Line stays released so the master can stop
                            state_nxt = ST_IDLE; // [RULE_07]
                            standby_nxt = 1'b1; // [RULE_08]
                        end
                    end
                end
                default: begin
                    // Illegal code: recover to standby with the line free
                    state_nxt = ST_IDLE; // [RULE_09]
                    sda_oe_nxt = 1'b0;
                    standby_nxt = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    // Reset lands in standby with SDA released
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scl_d_r <= LINE_IDLE;
            sda_d_r <= LINE_IDLE;
            state_r <= ST_IDLE; // [RULE_08]
            bit_cnt_r <= 3'h0;
            full_r <= 1'b0;
            shift_r <= BYTE_RESET;
            tx_r <= BYTE_RESET;
            rw_r <= 1'b0;
            master_ack_r <= 1'b0;
            sda_oe_r <= 1'b0;
            sda_out_r <= 1'b0;
            word_addr_r <= ADDR_RESET;
            prog_start_r <= 1'b0;
            prog_addr_r <= ADDR_RESET;
            prog_data_r <= BYTE_RESET;
            busy_r <= 1'b0;
            standby_r <= 1'b1;
        end else if (clk_en) begin
            scl_d_r <= scl_s; // [RULE_23]
            sda_d_r <= sda_s;
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            full_r <= full_nxt;
            shift_r <= shift_nxt;
            tx_r <= tx_nxt;
            rw_r <= rw_nxt;
            master_ack_r <= master_ack_nxt;
            sda_oe_r <= sda_oe_nxt;
            sda_out_r <= 1'b0;
            word_addr_r <= word_addr_nxt;
            prog_start_r <= prog_start_nxt;
            prog_addr_r <= prog_addr_nxt;
            prog_data_r <= prog_data_nxt;
            busy_r <= busy_nxt;
            standby_r <= standby_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pi.start = prog_start_r;
    assign sda_out = sda_out_r;
    assign sda_oe = sda_oe_r;
    assign word_addr = word_addr_r;
    assign prog_start = prog_start_r;
    assign prog_addr = prog_addr_r;
    assign prog_data = prog_data_r;
    assign busy = busy_r;
    assign standby = standby_r;

endmodule : eeprom_bus_slave

// file: test/bus_master_model.sv
`timescale 1ns/1ps
// Bus master stand-in: owns SCL, pulls SDA low while m_oe is high
module bus_master_model (
    input wire logic clock,
    input wire logic sda,
    output logic scl = 1'b1,
    output logic m_oe = 1'b0
);
    // One bus phase: set both lines at a falling edge, hold n core clocks
    task automatic step(input logic c, input logic o, input int n);
        scl = c;
        m_oe = o;
        repeat (n) @(negedge clock);
    endtask : step
    // Start, also as a repeated start from SCL low
    task automatic start();
        step(1'b0, 1'b0, 5);
        step(1'b1, 1'b0, 10);
        step(1'b1, 1'b1, 10);
        step(1'b0, 1'b1, 5);
    endtask : start
    task automatic stop();
        step(1'b0, 1'b1, 5);
        step(1'b1, 1'b1, 10);
        step(1'b1, 1'b0, 10);
    endtask : stop
    // Ninth bit stays released: it reads the ack, or sends a no_acknowledge on reads
    task automatic xfer(input logic [7:0] d, output logic [8:0] r);
        logic [8:0] v;
        v = {d, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            // 200 ns link period: 2 + 4 + 2 core clocks per bit
            step(1'b0, !v[i], 2);
            step(1'b1, m_oe, 4);
            r[i] = sda;
            step(1'b0, m_oe, 2);
        end
    endtask : xfer
endmodule : bus_master_model

// file: test/eeprom_bus_slave_checker.sv
`timescale 1ns/1ps
// Pin-level watch on the bus slave
module eeprom_bus_slave_checker #(parameter int WRITE_CYCLES = 50) (
    input wire logic clock, rst_n, scl_in, sda_in, sda_out, sda_oe,
    input wire logic prog_start, busy, standby,
    input wire logic [9:0] word_addr, prog_addr
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_only_pulls: assert property (!sda_out) else $error("sda high");
    a_start_wakes: assert property ($fell(sda_in) && scl_in && !busy
        |-> ##[1:6] !standby) else $error("no wake");
    a_stop_sleeps: assert property ($rose(sda_in) && scl_in && !busy
        |-> ##[1:6] (standby || busy)) else $error("no sleep");
    a_write_busy: assert property (prog_start |=> busy[*8]) else $error("no busy");
    a_busy_deaf: assert property (busy |-> !sda_oe) else $error("busy ack");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("moved");
    a_addr_step: assert property (prog_start |-> word_addr == prog_addr + 10'h1)
        else $error("bad addr");
    a_done_sleep: assert property ($fell(busy) |-> ##[0:1] standby) else $error("awake");
    a_idle_quiet: assert property (standby |-> !sda_oe) else $error("idle ack");
endmodule : eeprom_bus_slave_checker
bind eeprom_bus_slave eeprom_bus_slave_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
    .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .prog_start(prog_start), .busy(busy), .standby(standby),
    .word_addr(word_addr), .prog_addr(prog_addr));

// file: test/eeprom_bus_slave_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module eeprom_bus_slave_tb;
    logic clock = 1'b0, rst_n = 1'b0, scl, m_oe, sda, sda_oe, busy, standby;
    logic [9:0] word_addr, prog_addr;
    logic [7:0] prog_data;
    logic [8:0] r;
    int failures = 0, compares = 0;
    // Open-drain wire with pull-up: low while either side pulls
    assign sda = ~(sda_oe | m_oe);
    bus_master_model bm (.clock(clock), .sda(sda), .scl(scl), .m_oe(m_oe));
    // Memory stand-in: byte content follows its address
    eeprom_bus_slave #(.WRITE_CYCLES(400)) uut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
        .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .hw_select_bit(1'b1),
        .rd_data(word_addr[7:0] ^ 8'h5a), .word_addr(word_addr), .prog_start(),
        .prog_addr(prog_addr), .prog_data(prog_data), .busy(busy), .standby(standby));
    initial forever #12.5 clock = ~clock;
    // Byte write, then a probe while programming runs
    task automatic t_write();
        bm.start();
        bm.xfer(8'h5c, r);
        `CHK(r[0], 1'b0)
        bm.xfer(8'h3c, r);
        `CHK(r[0], 1'b0)
        bm.xfer(8'ha5, r);
        `CHK(r[0], 1'b0)
        bm.stop();
        `CHK({busy, prog_addr, prog_data}, {1'b1, 10'h23c, 8'ha5})
        bm.start();
        bm.xfer(8'h5c, r);
        `CHK(r[0], 1'b1)
        bm.stop();
        for (int i = 0; i < 1000 && busy; i++) @(negedge clock);
        `CHK({busy, standby, word_addr}, {2'b01, 10'h23d})
        $display("write done");
    endtask : t_write
    // Wrong select bit, then wrong type: refused, later bytes ignored
    task automatic t_mismatch();
        logic [7:0] bad [2] = '{8'h54, 8'h38};
        foreach (bad[i]) begin
            bm.start();
            bm.xfer(bad[i], r);
            `CHK({r[0], standby}, 2'b11)
            bm.xfer(8'h00, r);
            `CHK(r[0], 1'b1)
            bm.stop();
        end
        $display("mismatch done");
    endtask : t_mismatch
    // Dummy write, repeated start, one read byte closed by a no_acknowledge
    task automatic t_read();
        bm.start();
        bm.xfer(8'h5a, r);
        bm.xfer(8'h10, r);
        bm.start();
        bm.xfer(8'h5b, r);
        `CHK(r[0], 1'b0)
        bm.xfer(8'hff, r);
        // Standby follows the ninth fall by the sync and register delay
        repeat (3) @(negedge clock);
        `CHK({r[8:1], standby, sda}, {8'h4a, 2'b11})
        bm.stop();
        `CHK({word_addr, busy}, {10'h111, 1'b0})
        $display("read done");
    endtask : t_read
    // Read cut short with the line held low, dummy clocks, then a new command
    task automatic t_recover();
        bm.start();
        bm.xfer(8'h5b, r);
        repeat (3) @(negedge clock);
        `CHK(sda, 1'b0)
        for (int i = 0; i < 9 && !sda; i++) begin
            bm.step(1'b1, 1'b0, 4);
            bm.step(1'b0, 1'b0, 4);
        end
        `CHK(sda, 1'b1)
        bm.start();
        bm.xfer(8'h5c, r);
        `CHK(r[0], 1'b0)
        bm.stop();
        `CHK({standby, busy}, 2'b10)
        $display("recover done");
    endtask : t_recover
    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        `CHK(standby, 1'b1)
        t_write();
        t_mismatch();
        t_read();
        t_recover();
        print_verdict();
    end
    // Watchdog: about six times the expected run
    initial begin
        repeat (10000) @(posedge clock);
        failures++;
        print_verdict();
    end
endmodule : eeprom_bus_slave_tb
